/* core/hprs_cfg.svh */
// Constants: command codes, offsets, bit positions and timing counts
`ifndef HPRS_CFG_SVH
`define HPRS_CFG_SVH
// Command codes, used as register offsets
`define HPRS_CMD_POLL 8'h18
`define HPRS_CMD_SWFN 8'h1C
`define HPRS_CMD_WDOG 8'h1D
`define HPRS_CMD_STAT 8'h1E
// Reply codes
`define HPRS_RPL_POLL 8'h58
`define HPRS_RPL_SWFN 8'h5C
`define HPRS_RPL_WDOG 8'h5D
`define HPRS_RPL_STAT 8'h5E
`define HPRS_STAT_LEN 8'h0F
// Status byte window, high address nibble (byte i at 0x80+i)
`define HPRS_STAT_BASE 4'h8
// Key bit positions
`define HPRS_KEY_UP_BIT 0
`define HPRS_KEY_CONFIRM_BIT 1
`define HPRS_KEY_ABORT_BIT 2
`define HPRS_KEY_WEST_BIT 3
`define HPRS_KEY_EAST_BIT 4
`define HPRS_KEY_SOUTH_BIT 5
// Function mask bit positions
`define HPRS_FN_AUTO_POL 0
`define HPRS_FN_RST_INV 1
`define HPRS_FN_PWR_INV 2
`define HPRS_FN_BLANK_WHEN_HOST_DOWN 4
`define HPRS_FN_KEY_RESET 5
`define HPRS_FN_KEY_PWR_ON 6
`define HPRS_FN_KEY_PWR_OFF 7
// Reset values
`define HPRS_FMASK_RST 8'h00
`define HPRS_PLEN_RST 8'h20
`define HPRS_SRC_RST 1'b1
// Timing: clock, tick rate, durations in ms
`define HPRS_CLK_HZ 25000000
`define HPRS_TICK_HZ 32
`define HPRS_TICK_CYC (`HPRS_CLK_HZ / `HPRS_TICK_HZ)
`define HPRS_LONG_HOLD_MS 4000
`define HPRS_SHORT_HOLD_MS 250
`define HPRS_RST_PULSE_MS 1000
`define HPRS_EXTEND_MS 5000
`define HPRS_MS2TICK(ms) ((ms) * `HPRS_TICK_HZ / 1000)
// Display message codes
`define HPRS_MSG_NONE 2'h0
`define HPRS_MSG_RESET 2'h1
`define HPRS_MSG_PWR_ON 2'h2
`define HPRS_MSG_PWR_OFF 2'h3
`endif

/* core/hprs_pkg.sv */
// Types of the host power and reset supervisor
package hprs_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_EXTEND, ST_RESTART} hprs_st_t;

	// Settings owned by neighbouring blocks, shown in status readback
	typedef struct packed {
		logic [31:0] temp_mask;
		logic [7:0] key_press_mask;
		logic [7:0] key_rel_mask;
		logic [7:0] contrast;
		logic [7:0] key_bl;
		logic [7:0] contrast_alt;
		logic [7:0] lcd_bl;
	} hprs_ext_t;

	// Whole state of the supervisor
	typedef struct packed {
		hprs_st_t st;
		logic [5:0] held;
		logic [5:0] pressed;
		logic [5:0] released;
		logic [7:0] fmask;
		logic [7:0] plen;
		logic src;
		logic [7:0] wd;
		logic [7:0] hold;
		logic [7:0] cnt;
		logic go_boot;
		logic rst_oe_n;
		logic pwr_oe_n;
		logic rst_lvl;
		logic pwr_lvl;
		logic rst_idle;
		logic pwr_idle;
		logic sense;
		logic blank;
		logic [1:0] msg;
		logic restart;
		logic [31:0] rdata;
	} hprs_state_t;

	// State of the tick divider
	typedef struct packed {
		logic [19:0] div;
		logic [4:0] sub;
		logic t32;
		logic tsec;
	} hprs_tick_t;
endpackage : hprs_pkg

/* core/hprs_tick.sv */
// Divider making 1/32 s and 1 s tick pulses
`timescale 1ns/100ps
`include "hprs_cfg.svh"
module hprs_tick import hprs_pkg::*; #(
	parameter int CYC = `HPRS_TICK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Tick pulses
	output logic tick32,
	output logic tick_sec
);
	hprs_tick_t s_q, s_d;

	// Divider must fit its counter
	if (CYC < 2 || CYC > 1048576) begin : g_chk
		$error("hprs_tick: CYC out of range");
	end

	// Next state of the divider
	always_comb begin
		s_d = s_q;
		s_d.t32 = 1'b0;
		s_d.tsec = 1'b0;
		if (s_q.div == 20'(CYC - 1)) begin
			s_d.div = 20'h0_0000;
			s_d.t32 = 1'b1;
			s_d.sub = s_q.sub + 5'h01;
			s_d.tsec = (s_q.sub == 5'h1F);
		end else begin
			s_d.div = s_q.div + 20'h0_0001;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick32 = s_q.t32;
	assign tick_sec = s_q.tsec;
endmodule : hprs_tick

/* core/hprs_top.sv */
// Host power and reset supervisor: keypad poll, ATX pulses, watchdog
`timescale 1ns/100ps
`include "hprs_cfg.svh"
module hprs_top import hprs_pkg::*; #(
	parameter int TICK_CYC = `HPRS_TICK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Keypad and sense inputs
	input wire logic [5:0] keys,
	input wire logic sense_5v,
	input wire logic sense_gpio1,
	// Settings of neighbouring blocks
	input wire hprs_ext_t ext,
	// Host reset line
	input wire logic host_rst_i,
	output logic host_rst_o,
	output logic host_rst_oe_n,
	// Host power line
	input wire logic host_pwr_i,
	output logic host_pwr_o,
	output logic host_pwr_oe_n,
	// Display and self restart
	output logic display_off,
	output logic [1:0] msg,
	output logic self_restart
);
	localparam logic [7:0] LONG_T = 8'(`HPRS_MS2TICK(`HPRS_LONG_HOLD_MS));
	localparam logic [7:0] SHORT_T = 8'(`HPRS_MS2TICK(`HPRS_SHORT_HOLD_MS));
	localparam logic [7:0] RST_T = 8'(`HPRS_MS2TICK(`HPRS_RST_PULSE_MS));
	localparam logic [7:0] EXT_T = 8'(`HPRS_MS2TICK(`HPRS_EXTEND_MS));

	hprs_state_t s_q, s_d;
	logic tick32, tick_sec;
	logic sense_now, srise, busy, confirm, abort;
	logic [5:0] rise, fall;
	logic [7:0] hold_n;

	// Active level of a line: auto takes the opposite of its idle level
	function automatic logic act_lvl(input logic aut, input logic inv, input logic idle);
		return aut ? ~idle : inv;
	endfunction : act_lvl

	// One status byte by index
	function automatic logic [7:0] stat_byte(input logic [3:0] i, input hprs_state_t s,
		input hprs_ext_t e);
		logic [7:0] b;
		b = 8'h00;
		unique case (i)
			4'h1: b = e.temp_mask[7:0];
			4'h2: b = e.temp_mask[15:8];
			4'h3: b = e.temp_mask[23:16];
			4'h4: b = e.temp_mask[31:24];
			4'h5: b = e.key_press_mask;
			4'h6: b = e.key_rel_mask;
			4'h7: b = s.fmask;
			4'h8: b = s.wd;
			4'h9: b = e.contrast;
			4'hA: b = e.key_bl;
			4'hB: b = {7'h00, s.src};
			4'hD: b = e.contrast_alt;
			4'hE: b = e.lcd_bl;
			default: b = 8'h00;
		endcase
		return b;
	endfunction : stat_byte

	// Tick source
	hprs_tick #(
		.CYC(TICK_CYC)
	) u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.tick32(tick32),
		.tick_sec(tick_sec)
	);

	// Key edges, sense selection and hold counter
	assign rise = keys & ~s_q.held;
	assign fall = ~keys & s_q.held;
	assign sense_now = s_q.src ? sense_5v : sense_gpio1;
	assign srise = sense_now & ~s_q.sense;
	assign busy = (s_q.st != ST_IDLE);
	assign confirm = keys[`HPRS_KEY_CONFIRM_BIT];
	assign abort = keys[`HPRS_KEY_ABORT_BIT];
	assign hold_n = (tick32 && s_q.hold != 8'hFF) ? s_q.hold + 8'h01 : s_q.hold;

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.restart = 1'b0;
		s_d.rdata = 32'h0000_0000;
		s_d.held = keys;
		s_d.sense = sense_now;
		s_d.pressed = s_q.pressed | rise;
		s_d.released = s_q.released | fall;
		s_d.hold = (confirm | abort) ? hold_n : 8'h00;
		s_d.blank = s_q.fmask[`HPRS_FN_BLANK_WHEN_HOST_DOWN] & ~sense_now;
		// Learn idle levels while released
		if (s_q.rst_oe_n) begin
			s_d.rst_idle = host_rst_i;
		end
		if (s_q.pwr_oe_n) begin
			s_d.pwr_idle = host_pwr_i;
		end
		// Reads, all refused while busy
		if (rd && !busy) begin
			unique case (addr)
				`HPRS_CMD_POLL: begin
					s_d.rdata = {`HPRS_RPL_POLL, 2'b00, s_q.released, 2'b00, s_q.pressed,
						2'b00, s_q.held};
					s_d.pressed = rise;
					s_d.released = fall;
				end
				`HPRS_CMD_SWFN: s_d.rdata = {`HPRS_RPL_SWFN, 24'h00_0000};
				`HPRS_CMD_WDOG: s_d.rdata = {`HPRS_RPL_WDOG, 24'h00_0000};
				`HPRS_CMD_STAT: s_d.rdata = {`HPRS_RPL_STAT, 16'h0000, `HPRS_STAT_LEN};
				default: begin
					if (addr[7:4] == `HPRS_STAT_BASE && addr[3:0] != 4'hF) begin
						s_d.rdata = {24'h00_0000, stat_byte(addr[3:0], s_q, ext)};
					end
				end
			endcase
		end
		// Writes, all refused while busy
		if (wr && !busy) begin
			if (addr == `HPRS_CMD_SWFN && wdata[31:24] >= 8'h01 && wdata[31:24] <= 8'h03) begin
				s_d.fmask = wdata[7:0];
				if (wdata[31:24] >= 8'h02) begin
					s_d.plen = (wdata[15:8] == 8'h00) ? 8'h01 : wdata[15:8];
				end
				if (wdata[31:24] == 8'h03) begin
					s_d.src = wdata[16];
				end
			end
			if (addr == `HPRS_CMD_WDOG) begin
				s_d.wd = wdata[7:0];
			end
		end
		// Sequencer
		unique case (s_q.st)
			ST_IDLE: begin
				if (tick_sec && s_q.wd == 8'h01 && !(wr && addr == `HPRS_CMD_WDOG)) begin
					s_d.wd = 8'h00;
					s_d.st = ST_PULSE;
					s_d.rst_oe_n = 1'b0;
					s_d.rst_lvl = act_lvl(s_q.fmask[`HPRS_FN_AUTO_POL],
						s_q.fmask[`HPRS_FN_RST_INV], s_q.rst_idle);
					s_d.cnt = RST_T;
					s_d.go_boot = 1'b0;
				end else if (srise) begin
					s_d.st = ST_RESTART;
				end else begin
					if (tick_sec && s_q.wd > 8'h01 && !(wr && addr == `HPRS_CMD_WDOG)) begin
						s_d.wd = s_q.wd - 8'h01;
					end
					if (tick32 && s_q.fmask[`HPRS_FN_KEY_RESET] && sense_now && confirm &&
						hold_n == LONG_T) begin
						s_d.st = ST_PULSE;
						s_d.rst_oe_n = 1'b0;
						s_d.rst_lvl = act_lvl(s_q.fmask[`HPRS_FN_AUTO_POL],
							s_q.fmask[`HPRS_FN_RST_INV], s_q.rst_idle);
						s_d.cnt = RST_T;
						s_d.go_boot = 1'b1;
						s_d.msg = `HPRS_MSG_RESET;
					end else if (tick32 && s_q.fmask[`HPRS_FN_KEY_PWR_ON] && !sense_now &&
						confirm && hold_n == SHORT_T) begin
						s_d.st = ST_PULSE;
						s_d.pwr_oe_n = 1'b0;
						s_d.pwr_lvl = act_lvl(s_q.fmask[`HPRS_FN_AUTO_POL],
							s_q.fmask[`HPRS_FN_PWR_INV], s_q.pwr_idle);
						s_d.cnt = s_q.plen;
						s_d.go_boot = 1'b1;
						s_d.msg = `HPRS_MSG_PWR_ON;
					end else if (tick32 && s_q.fmask[`HPRS_FN_KEY_PWR_OFF] && sense_now &&
						abort && hold_n == LONG_T) begin
						s_d.st = ST_PULSE;
						s_d.pwr_oe_n = 1'b0;
						s_d.pwr_lvl = act_lvl(s_q.fmask[`HPRS_FN_AUTO_POL],
							s_q.fmask[`HPRS_FN_PWR_INV], s_q.pwr_idle);
						s_d.cnt = s_q.plen;
						s_d.go_boot = 1'b0;
						s_d.msg = `HPRS_MSG_PWR_OFF;
					end
				end
			end
			ST_PULSE: begin
				if (tick32) begin
					if (s_q.cnt > 8'h01) begin
						s_d.cnt = s_q.cnt - 8'h01;
					end else if (!s_q.pwr_oe_n && !s_q.go_boot && abort) begin
						s_d.st = ST_EXTEND;
						s_d.cnt = EXT_T;
					end else begin
						s_d.rst_oe_n = 1'b1;
						s_d.pwr_oe_n = 1'b1;
						s_d.st = s_q.go_boot ? ST_RESTART : ST_IDLE;
						if (!s_q.go_boot) begin
							s_d.msg = `HPRS_MSG_NONE;
						end
					end
				end
			end
			ST_EXTEND: begin
				if (!abort || (tick32 && s_q.cnt == 8'h01)) begin
					s_d.pwr_oe_n = 1'b1;
					s_d.msg = `HPRS_MSG_NONE;
					s_d.st = ST_IDLE;
				end else if (tick32) begin
					s_d.cnt = s_q.cnt - 8'h01;
				end
			end
			ST_RESTART: begin
				s_d.restart = 1'b1;
				s_d.pressed = 6'h00;
				s_d.released = 6'h00;
				s_d.wd = 8'h00;
				s_d.msg = `HPRS_MSG_NONE;
				s_d.go_boot = 1'b0;
				s_d.st = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: ST_IDLE, fmask: `HPRS_FMASK_RST, plen: `HPRS_PLEN_RST,
				src: `HPRS_SRC_RST, rst_oe_n: 1'b1, pwr_oe_n: 1'b1, rst_idle: 1'b1,
				pwr_idle: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign rdata = s_q.rdata;
	assign host_rst_o = s_q.rst_lvl;
	assign host_rst_oe_n = s_q.rst_oe_n;
	assign host_pwr_o = s_q.pwr_lvl;
	assign host_pwr_oe_n = s_q.pwr_oe_n;
	assign display_off = s_q.blank;
	assign msg = s_q.msg;
	assign self_restart = s_q.restart;

	// Checks
	AST_POLL_CODE: assert property (@(posedge clk) disable iff (!rst_n)
		rd && !busy && addr == `HPRS_CMD_POLL |=> rdata[31:24] == 8'h58 && rdata[7:6] == 2'b00)
		else $error("poll reply code wrong");
	AST_HIST_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		rd && !busy && addr == `HPRS_CMD_POLL && keys == s_q.held |=>
		s_q.pressed == 6'h00 && s_q.released == 6'h00)
		else $error("history not cleared by poll");
	AST_IDLE_HIZ: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.st == ST_IDLE || s_q.st == ST_RESTART |-> host_rst_oe_n && host_pwr_oe_n)
		else $error("line driven while idle");
	AST_DEF_POL: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(host_rst_oe_n) && !$past(s_q.fmask[0]) && !$past(s_q.fmask[1]) |->
		host_rst_o == 1'b0)
		else $error("reset line not driven low");
	AST_BUSY_IGN: assert property (@(posedge clk) disable iff (!rst_n)
		busy && wr |=> s_q.fmask == $past(s_q.fmask))
		else $error("command taken while busy");
	AST_WD_FIRE: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.st == ST_IDLE && tick_sec && s_q.wd == 8'h01 && !wr |=>
		!host_rst_oe_n && s_q.wd == 8'h00)
		else $error("watchdog did not fire");
	AST_BLANK: assert property (@(posedge clk) disable iff (!rst_n)
		##1 display_off == ($past(s_q.fmask[4]) && !$past(sense_now)))
		else $error("blanking wrong");
	AST_SENSE_BOOT: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.st == ST_IDLE && srise && !(tick_sec && s_q.wd == 8'h01) |=> ##1 self_restart)
		else $error("no restart on sense rise");
	AST_STAT_LEN: assert property (@(posedge clk) disable iff (!rst_n)
		rd && !busy && addr == `HPRS_CMD_STAT |=> rdata == 32'h5E00_000F)
		else $error("status reply wrong");
endmodule : hprs_top

/* tb/hprs_host_model.sv */
// Model of the host board's power and reset switch inputs
`timescale 1ns/100ps
module hprs_host_model #(
	parameter bit RST_IDLE = 1'b1,
	parameter bit PWR_IDLE = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Lines from the supervisor
	input wire logic rst_o,
	input wire logic rst_oe_n,
	input wire logic pwr_o,
	input wire logic pwr_oe_n,
	// Resolved line levels
	output logic rst_lvl,
	output logic pwr_lvl,
	// Pulse counts, widths in cycles and driven levels
	output int n_rst,
	output int n_pwr,
	output int w_rst,
	output int w_pwr,
	output logic l_rst,
	output logic l_pwr
);
	int cr;
	int cp;
	// Released lines sit at the board resistor level
	assign rst_lvl = rst_oe_n ? RST_IDLE : rst_o;
	assign pwr_lvl = pwr_oe_n ? PWR_IDLE : pwr_o;
	// Measure every pulse the supervisor drives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cr <= 0;
			cp <= 0;
			n_rst <= 0;
			n_pwr <= 0;
		end else begin
			cr <= rst_oe_n ? 0 : cr + 1;
			cp <= pwr_oe_n ? 0 : cp + 1;
			if (!rst_oe_n) l_rst <= rst_lvl;
			if (!pwr_oe_n) l_pwr <= pwr_lvl;
			if (rst_oe_n && cr != 0) begin
				n_rst <= n_rst + 1;
				w_rst <= cr;
			end
			if (pwr_oe_n && cp != 0) begin
				n_pwr <= n_pwr + 1;
				w_pwr <= cp;
			end
		end
	end
endmodule : hprs_host_model

/* tb/tb_host_power_reset_supervisor.sv */
// Bench of the supervisor against a behavioural model and a host board model
`timescale 1ns/100ps
module tb_host_power_reset_supervisor import hprs_pkg::*;;
	localparam int TC = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [5:0] keys = 6'h00;
	logic s5 = 1'b0;
	logic sg = 1'b0;
	hprs_ext_t ext;
	logic ro, roe, rl, po, poe, pl, doff, srst, lr, lp;
	logic [1:0] msg;
	int nr, np, wrw, wpw;
	int n_fail = 0;
	int checked = 0;
	int seed = 61;
	int cyc = 0;
	int mh = 0;
	int mp = 0;
	int mr = 0;
	int nrs = 0;
	int ers = 0;
	int n;

	// Clock
	initial begin
		forever #20 clk = ~clk;
	end

	// Device under test and host board
	hprs_top #(.TICK_CYC(TC)) hprs_top_i (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .keys(keys), .sense_5v(s5),
		.sense_gpio1(sg), .ext(ext), .host_rst_i(rl), .host_rst_o(ro),
		.host_rst_oe_n(roe), .host_pwr_i(pl), .host_pwr_o(po), .host_pwr_oe_n(poe),
		.display_off(doff), .msg(msg), .self_restart(srst));
	hprs_host_model #(.RST_IDLE(1'b0), .PWR_IDLE(1'b1)) hprs_host_model_i (.clk(clk),
		.rst_n(rst_n), .rst_o(ro), .rst_oe_n(roe), .pwr_o(po), .pwr_oe_n(poe),
		.rst_lvl(rl), .pwr_lvl(pl), .n_rst(nr), .n_pwr(np), .w_rst(wrw), .w_pwr(wpw),
		.l_rst(lr), .l_pwr(lp));

	// Compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic report_and_stop;
		if (n_fail == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// Bus cycles
	task automatic wcmd(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wcmd

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rchk

	// Key levels with history kept by the model
	task automatic setk(input logic [5:0] k);
		mp |= k & ~mh;
		mr |= mh & ~k;
		mh = k;
		keys <= k;
		@(posedge clk);
		#1;
	endtask : setk

	// Bounded wait: 0 power driven, 1 reset driven, 2 restart, 3 both released
	task automatic waitc(input int sel, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge clk);
			#1;
			if ((sel == 0 && !poe) || (sel == 1 && !roe) || (sel == 2 && nrs > ers)) break;
			if (sel == 3 && poe && roe) break;
		end
		if (i == lim) chk(1, 0);
		else if (sel == 2) ers++;
	endtask : waitc

	// One pulse: message, refused read, width in ticks, driven level
	task automatic pulse(input int sel, input int m, input int tk, input logic lv);
		waitc(sel, 3000);
		setk(6'h00);
		if (m >= 0) begin
			chk(msg, m);
			rchk(8'h1C, 32'h0000_0000);
			wcmd(8'h1C, 32'h0100_0000);
		end
		waitc(3, 3000);
		@(posedge clk);
		#1;
		n = sel ? wrw : wpw;
		chk(n >= (tk - 1) * TC && n <= (tk + 1) * TC, 1);
		chk(sel ? lr : lp, lv);
	endtask : pulse

	// Status window against expected bytes
	task automatic stat(input logic [7:0] fm, input logic [7:0] wd, input logic sr);
		logic [7:0] e[15];
		e = '{8'h00, ext.temp_mask[7:0], ext.temp_mask[15:8], ext.temp_mask[23:16],
			ext.temp_mask[31:24], ext.key_press_mask, ext.key_rel_mask, fm, wd,
			ext.contrast, ext.key_bl, {7'h00, sr}, 8'h00, ext.contrast_alt, ext.lcd_bl};
		for (int i = 0; i < 15; i++) rchk(8'h80 + 8'(i), {24'h00_0000, e[i]});
	endtask : stat

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			chk(1, 0);
			report_and_stop();
		end
	end

	// Restart pulses, counted at the edge after they stand so none is missed
	always @(posedge clk) begin
		if (srst) nrs++;
	end

	// Main sequence
	initial begin
		ext.temp_mask <= {4{8'($random(seed))}};
		ext[47:0] <= {$random(seed), 16'($random(seed))};
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk({roe, poe, doff, srst, msg}, 6'b11_0000);
		rchk(8'h1C, 32'h5C00_0000);
		rchk(8'h1D, 32'h5D00_0000);
		rchk(8'h1E, 32'h5E00_000F);
		rchk(8'h40, 32'h0000_0000);
		wcmd(8'h1C, 32'h0000_0080);
		wcmd(8'h1C, 32'h0400_00FF);
		stat(8'h00, 8'h00, 1'b1);
		for (int i = 0; i < 24; i++) begin
			setk(6'($random(seed)));
			if (i == 12) begin
				ext.key_press_mask <= 8'h00;
				ext.key_rel_mask <= 8'h00;
			end
			if (i % 4 == 3) begin
				repeat (2) @(posedge clk);
				rchk(8'h18, {8'h58, 2'b00, 6'(mr), 2'b00, 6'(mp), 2'b00, 6'(mh)});
				mp = 0;
				mr = 0;
				rchk(8'h18, {8'h58, 2'b00, 6'h00, 2'b00, 6'h00, 2'b00, 6'(mh)});
			end
		end
		setk(6'h00);
		repeat (300) @(posedge clk);
		wcmd(8'h1C, 32'h0301_0341);
		rchk(8'h87, 32'h0000_0041);
		setk(6'h02);
		pulse(0, 2, 3, 1'b0);
		waitc(2, 50);
		repeat (20) @(posedge clk);
		s5 <= 1'b1;
		waitc(2, 4);
		repeat (20) @(posedge clk);
		wcmd(8'h1C, 32'h0201_0284);
		setk(6'h04);
		pulse(0, 3, 2, 1'b1);
		setk(6'h04);
		waitc(0, 3000);
		repeat (100) @(posedge clk);
		setk(6'h00);
		waitc(3, 20);
		@(posedge clk);
		#1;
		chk(wpw >= 100 && wpw <= 104, 1);
		wcmd(8'h1C, 32'h0100_0020);
		setk(6'h02);
		pulse(1, 1, 32, 1'b0);
		waitc(2, 50);
		repeat (20) @(posedge clk);
		wcmd(8'h1C, 32'h0100_0001);
		wcmd(8'h1D, 32'h0000_0003);
		repeat (200) @(posedge clk);
		n = nr;
		wcmd(8'h1D, 32'h0000_0003);
		repeat (200) @(posedge clk);
		chk(nr, n);
		pulse(1, -1, 32, 1'b1);
		rchk(8'h88, 32'h0000_0000);
		wcmd(8'h1C, 32'h0300_0110);
		repeat (3) @(posedge clk);
		#1;
		chk(doff, 1'b1);
		sg <= 1'b1;
		waitc(2, 4);
		chk(doff, 1'b0);
		s5 <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk(doff, 1'b0);
		chk(nrs, ers);
		report_and_stop();
	end
endmodule : tb_host_power_reset_supervisor
